// ---- core/flash_seq_pkg.sv ----
// shared constants and carrier types for the data flash rewrite sequencer
// assumes one 50 MHz clock and a cpu that writes 8-bit special registers
package flash_seq_pkg;

	// ------------------------------------------------------------------
	// register selectors on the cpu write port
	// ------------------------------------------------------------------
	localparam logic [3:0] SEL_ADDR_LOW   = 4'h0; // target_addr_low
	localparam logic [3:0] SEL_ADDR_HIGH  = 4'h1; // target_addr_high
	localparam logic [3:0] SEL_DATA_LOW   = 4'h2; // program_data_low
	localparam logic [3:0] SEL_DATA_HIGH  = 4'h3; // program_data_high
	localparam logic [3:0] SEL_ERASE_CMD  = 4'h4; // erase_command_reg
	localparam logic [3:0] SEL_UNLOCK     = 4'h5; // rewrite_unlock_key
	localparam logic [3:0] SEL_SEGMENT    = 4'h6; // segment_select_reg
	localparam logic [3:0] SEL_ENABLE     = 4'h7; // rewrite_enable_reg
	localparam logic [3:0] SEL_AREA_LOCK  = 4'h8; // area_lock_reg
	localparam logic [3:0] SEL_ABORT_SRC  = 4'he; // abort_source_select
	localparam logic [3:0] SEL_ERASE_STAT = 4'hf; // erase status

	// ------------------------------------------------------------------
	// keys, field positions, reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] KEY_FIRST      = 8'hfa;
	localparam logic [7:0] KEY_SECOND     = 8'hf5;
	localparam int         BIT_ENABLE     = 0;
	localparam int         BIT_SECTOR     = 0;
	localparam int         BIT_BLOCK      = 1;
	localparam int         BIT_ABORTED    = 7;
	localparam logic [1:0] SEGMENT_TWO    = 2'b10;
	localparam logic [1:0] SEGMENT_RESET  = 2'b00;
	localparam logic [7:0] BYTE_RESET     = 8'h00;
	localparam logic [3:0] LOCK_RESET     = 4'h0;
	localparam logic [15:0] ERASED_WORD   = 16'hffff;

	// ------------------------------------------------------------------
	// array geometry: 4k bytes of segment 2 as 2048 words
	// ------------------------------------------------------------------
	localparam int ARRAY_WORDS   = 2048;
	localparam int SECTOR_WORDS  = 512;  // 1k bytes
	localparam int BLOCK_WORDS   = 2048; // 4k bytes

	// ------------------------------------------------------------------
	// timing: program time, turned into cycles at 50 MHz
	// ------------------------------------------------------------------
	localparam int CLOCK_HZ        = 50_000_000;
	localparam int PROGRAM_TIME_US = 40;
	localparam int PROGRAM_CYCLES  = PROGRAM_TIME_US * (CLOCK_HZ / 1_000_000);

	// ------------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic       strobe; // one-cycle write pulse
		logic [3:0] sel;    // register selector
		logic [7:0] data;   // byte written
	} cpu_write_type;

	typedef enum logic [1:0] {
		OP_SECTOR,
		OP_BLOCK,
		OP_WORD
	} op_kind_type;

	typedef struct packed {
		logic        start;  // one-cycle launch
		op_kind_type kind;
		logic [10:0] word;   // word address inside segment 2
		logic [15:0] data;   // word to program
	} array_cmd_type;

endpackage

// ---- core/flash_array_core.sv ----
// word-organised model of the data flash array with erase and program timing
// assumes launches arrive only while o_busy is low
`timescale 1ns/10ps
module flash_array_core
	import flash_seq_pkg::*;
#(
	parameter int ERASE_CYCLES = 4096 // default erase time in cycles
) (
	// clock and reset
	input  wire logic          i_clock,
	input  wire logic          i_rst_n,
	// command side
	input  wire array_cmd_type i_cmd,
	input  wire logic          i_abort,
	input  wire logic [10:0]   i_read_word,
	output logic               o_busy,
	output logic               o_done,
	output logic               o_aborted,
	output logic [15:0]        o_read_data
);

	// ------------------------------------------------------------------
	// storage and progress
	// ------------------------------------------------------------------
	logic [15:0] mem [ARRAY_WORDS];   // the array itself
	logic [31:0] timer_q;             // remaining busy cycles
	logic [10:0] base_q;              // first word of the op
	logic [11:0] span_q;              // words the op covers
	op_kind_type kind_q;
	logic [10:0] word_q;
	logic [15:0] data_q;

	// busy timer, latch of the command
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			timer_q   <= '0;
			o_busy    <= 1'b0;
			o_done    <= 1'b0;
			o_aborted <= 1'b0;
			base_q    <= '0;
			span_q    <= '0;
			kind_q    <= OP_WORD;
			word_q    <= '0;
			data_q    <= '0;
		end else begin
			o_done    <= 1'b0;
			o_aborted <= 1'b0;
			if (i_cmd.start && !o_busy) begin
				o_busy <= 1'b1;
				kind_q <= i_cmd.kind;
				word_q <= i_cmd.word;
				data_q <= i_cmd.data;
				if (i_cmd.kind == OP_SECTOR) begin
					base_q  <= {i_cmd.word[10:9], 9'h000};
					span_q  <= 12'(SECTOR_WORDS);
					timer_q <= 32'(ERASE_CYCLES);
				end else if (i_cmd.kind == OP_BLOCK) begin
					base_q  <= 11'h000;
					span_q  <= 12'(BLOCK_WORDS);
					timer_q <= 32'(ERASE_CYCLES);
				end else begin
					span_q  <= 12'h001;
					timer_q <= 32'(PROGRAM_CYCLES);
				end
			end else if (o_busy) begin
				// erases may be cut short; a program always finishes
				if (i_abort && kind_q != OP_WORD) begin
					o_busy    <= 1'b0;
					o_aborted <= 1'b1;
				end else if (timer_q <= 32'h1) begin
					o_busy <= 1'b0;
					o_done <= 1'b1;
				end else begin
					timer_q <= timer_q - 32'h1;
				end
			end
		end
	end

	// array contents change only on a finished operation
	always_ff @(posedge i_clock) begin
		if (o_busy && timer_q <= 32'h1
		    && !(i_abort && kind_q != OP_WORD)) begin
			if (kind_q == OP_WORD) begin
				mem[word_q] <= mem[word_q] & data_q; // program clears bits
			end else begin
				for (int i = 0; i < ARRAY_WORDS; i++) begin
					if (12'(i) >= {1'b0, base_q}
					    && 12'(i) < {1'b0, base_q} + span_q) begin
						mem[i] <= ERASED_WORD;
					end
				end
			end
		end
	end

	// registered read port
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_read_data <= '0;
		end else begin
			o_read_data <= mem[i_read_word];
		end
	end

endmodule

// ---- core/flash_rewrite_seq.sv ----
// data flash self-rewrite sequencer: special registers, unlock, protection
// assumes the cpu issues one-cycle byte writes and obeys o_cpu_stall
// while the array works the cpu is stalled; writes are dropped
// except the erase status clear
// array words are not reset and read unknown until erased
// program and erase share one busy timer in the array core
`timescale 1ns/10ps
module flash_rewrite_seq
	import flash_seq_pkg::*;
#(
	parameter int ERASE_CYCLES = 4096 // erase time, shorten in simulation
) (
	// clock and reset
	input  wire logic          i_clock,
	input  wire logic          i_rst_n,
	// cpu register writes
	input  wire cpu_write_type i_cpu_wr,
	// abort interrupt sources, already in this clock domain
	input  wire logic [7:0]    i_ext_irq,
	// array read port for the cpu
	input  wire logic [10:0]   i_read_word,
	output logic [15:0]        o_read_data,
	// cpu handshake
	output logic               o_cpu_stall,
	// status and register read-back
	output logic               o_rewrite_enable_bit,
	output logic [1:0]         o_segment_select,
	output logic [3:0]         o_area_lock,
	output logic [7:0]         o_abort_source_select,
	output logic               o_erase_aborted_flag,
	output logic               o_refused,
	output logic               o_unlock_armed
);

	// ------------------------------------------------------------------
	// register state
	// ------------------------------------------------------------------
	logic [7:0]  addr_low_q;    // target_addr_low
	logic [7:0]  addr_high_q;   // target_addr_high
	logic [7:0]  data_low_q;    // program_data_low
	logic [1:0]  segment_q;     // segment_select_hi/lo
	logic        enable_q;      // rewrite_enable_bit
	logic [3:0]  lock_q;        // area_lock_q0..3
	logic [7:0]  abort_sel_q;   // abort_source_select
	logic        aborted_q;     // erase_aborted_flag
	logic        first_key_q;   // first key seen
	logic        armed_q;       // full unlock seen
	logic        refused_q;     // last start refused
	logic        erasing_q;     // running op is an erase

	// ------------------------------------------------------------------
	// decode of the three start requests
	// ------------------------------------------------------------------
	logic          wr_sel_enable, wr_sel_unlock, wr_sel_cmd, wr_sel_dh;
	logic          req_sector, req_block, req_word, req_any;
	logic          allowed;
	array_cmd_type cmd;
	logic          array_busy, array_done, array_aborted;

	// true when a write strobe targets the given selector
	function automatic logic hit(input cpu_write_type w,
	                             input logic [3:0] sel);
		hit = w.strobe && (w.sel == sel);
	endfunction

	// byte address bits 11:10 sit in bits 3:2 of the high byte
	// lock bit of the 1k quarter that holds a byte address
	function automatic logic quarter_locked(input logic [3:0] lk,
	                                        input logic [7:0] hi);
		quarter_locked = lk[hi[3:2]];
	endfunction

	assign wr_sel_enable = hit(i_cpu_wr, SEL_ENABLE);
	assign wr_sel_unlock = hit(i_cpu_wr, SEL_UNLOCK);
	assign wr_sel_cmd    = hit(i_cpu_wr, SEL_ERASE_CMD);
	assign wr_sel_dh     = hit(i_cpu_wr, SEL_DATA_HIGH);
	// sector has priority when both command bits are written at once
	assign req_sector = wr_sel_cmd && i_cpu_wr.data[BIT_SECTOR];
	assign req_block  = wr_sel_cmd && !i_cpu_wr.data[BIT_SECTOR]
	                    && i_cpu_wr.data[BIT_BLOCK];
	assign req_word   = wr_sel_dh;
	// starts are ignored while the array is busy; the cpu is stalled then
	assign req_any    = (req_sector || req_block || req_word) && !array_busy;

	// protection uses the address bytes as they stand at the start
	// write, so a late address change is still seen in time
	// permission check shared by all three operations
	always_comb begin
		allowed = enable_q && armed_q
		          && (segment_q == SEGMENT_TWO);
		if (req_sector) begin
			allowed = allowed && !quarter_locked(lock_q, addr_high_q);
		end else if (req_block) begin
			allowed = allowed && (lock_q == LOCK_RESET);
		end else begin
			// program honours the same quarter locks as sector erase
			allowed = allowed && !quarter_locked(lock_q, addr_high_q);
		end
	end

	// a refusal keeps the stall low, so the cpu never waits
	// launch toward the array; refused starts never reach it
	always_comb begin
		cmd.start = req_any && allowed;
		if (req_sector) begin
			cmd.kind = OP_SECTOR;
		end else if (req_block) begin
			cmd.kind = OP_BLOCK;
		end else begin
			cmd.kind = OP_WORD;
		end
		// bit 0 of the low address byte is ignored: words are aligned
		cmd.word = {addr_high_q[3:0], addr_low_q[7:1]};
		cmd.data = {i_cpu_wr.data, data_low_q};
	end

	// ------------------------------------------------------------------
	// plain register writes
	// ------------------------------------------------------------------
	// writes while busy are dropped; the running operation works from
	// its own copy of address and data, latched in the array core
	// address, data, segment and abort source bytes
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			addr_low_q  <= BYTE_RESET;
			addr_high_q <= BYTE_RESET;
			data_low_q  <= BYTE_RESET;
			segment_q   <= SEGMENT_RESET;
			abort_sel_q <= BYTE_RESET;
		end else if (!array_busy) begin
			if (hit(i_cpu_wr, SEL_ADDR_LOW)) begin
				addr_low_q <= i_cpu_wr.data;
			end
			if (hit(i_cpu_wr, SEL_ADDR_HIGH)) begin
				addr_high_q <= i_cpu_wr.data;
			end
			if (hit(i_cpu_wr, SEL_DATA_LOW)) begin
				data_low_q <= i_cpu_wr.data;
			end
			if (hit(i_cpu_wr, SEL_SEGMENT)) begin
				segment_q <= i_cpu_wr.data[1:0];
			end
			if (hit(i_cpu_wr, SEL_ABORT_SRC)) begin
				abort_sel_q <= i_cpu_wr.data;
			end
		end
	end

	// clearing it takes effect at once, even with the unlock armed
	// rewrite enable bit, cleared by reset
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			enable_q <= 1'b0;
		end else if (wr_sel_enable && !array_busy) begin
			enable_q <= i_cpu_wr.data[BIT_ENABLE];
		end
	end

	// only reset clears a lock, so a runaway program cannot undo
	// a lock that boot code has set
	// lock bits only ever set; a written zero is ignored
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lock_q <= LOCK_RESET;
		end else if (hit(i_cpu_wr, SEL_AREA_LOCK) && !array_busy) begin
			lock_q <= lock_q | i_cpu_wr.data[3:0];
		end
	end

	// ------------------------------------------------------------------
	// unlock key sequence
	// ------------------------------------------------------------------
	// a start consumes the unlock even when refused, so a stray
	// start never leaves the array open for a second try
	// writes to registers other than the key register between the keys, starts aside, do not disturb the pair
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			first_key_q <= 1'b0;
			armed_q     <= 1'b0;
		end else if (req_any) begin
			first_key_q <= 1'b0;
			armed_q     <= 1'b0;
		end else if (wr_sel_unlock && !array_busy) begin
			if (first_key_q && i_cpu_wr.data == KEY_SECOND) begin
				armed_q     <= 1'b1;
				first_key_q <= 1'b0;
			end else if (i_cpu_wr.data == KEY_FIRST) begin
				first_key_q <= 1'b1;
				armed_q     <= 1'b0;
			end else begin
				first_key_q <= 1'b0;
				armed_q     <= 1'b0;
			end
		end
	end

	// only the latest start is reported; read it before the next
	// refusal indicator, updated on every start request
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			refused_q <= 1'b0;
		end else if (req_any) begin
			refused_q <= !allowed;
		end
	end

	// ------------------------------------------------------------------
	// kind of the running operation
	// ------------------------------------------------------------------
	// a finished program leaves the abort status alone; an erase not
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			erasing_q <= 1'b0;
		end else if (cmd.start) begin
			erasing_q <= (cmd.kind != OP_WORD);
		end
	end

	// ------------------------------------------------------------------
	// erase abort status
	// ------------------------------------------------------------------
	// the abort event wins over a software clear in the same cycle
	// a clean erase end clears it, so a re-run shows success
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			aborted_q <= 1'b0;
		end else if (array_aborted) begin
			aborted_q <= 1'b1;
		end else if (array_done && erasing_q) begin
			aborted_q <= 1'b0;
		end else if (hit(i_cpu_wr, SEL_ERASE_STAT)
		             && !i_cpu_wr.data[BIT_ABORTED]) begin
			aborted_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// array with its timing
	// ------------------------------------------------------------------
	// several sources may be selected; the first that fires
	// ends the erase
	flash_array_core #(
		.ERASE_CYCLES (ERASE_CYCLES)
	) u_array (
		.i_clock     (i_clock),
		.i_rst_n     (i_rst_n),
		.i_cmd       (cmd),
		.i_abort     (|(i_ext_irq & abort_sel_q)),
		.i_read_word (i_read_word),
		.o_busy      (array_busy),
		.o_done      (array_done),
		.o_aborted   (array_aborted),
		.o_read_data (o_read_data)
	);

	// the two idle slots after a start are left to software
	// stall covers the launch cycle and the whole busy time, so the
	// cpu resumes at the instruction after the starting write
	assign o_cpu_stall = cmd.start || array_busy;

	// ------------------------------------------------------------------
	// status outputs
	// ------------------------------------------------------------------
	// straight from the registers, so what is seen is what the
	// next start will be checked against
	assign o_rewrite_enable_bit  = enable_q;
	assign o_segment_select      = segment_q;
	assign o_area_lock           = lock_q;
	assign o_abort_source_select = abort_sel_q;
	assign o_erase_aborted_flag  = aborted_q;
	assign o_refused             = refused_q;
	assign o_unlock_armed        = armed_q;

endmodule

// ---- verif/flash_seq_checker.sv ----
// assertions on the rewrite sequencer ports, bound into its top module
// assumes one-cycle write strobes and the combinational stall output
`timescale 1ns/10ps
module flash_seq_checker
	import flash_seq_pkg::*;
#(
	parameter int ERASE_CYCLES = 4096 // erase time in cycles
) (
	// clock and reset
	input  wire logic          i_clock,
	input  wire logic          i_rst_n,
	// cpu side
	input  wire cpu_write_type i_cpu_wr,
	input  wire logic [7:0]    i_ext_irq,
	// sequencer outputs
	input  wire logic          o_cpu_stall,
	input  wire logic          o_rewrite_enable_bit,
	input  wire logic [1:0]    o_segment_select,
	input  wire logic [3:0]    o_area_lock,
	input  wire logic [7:0]    o_abort_source_select,
	input  wire logic          o_erase_aborted_flag,
	input  wire logic          o_refused,
	input  wire logic          o_unlock_armed
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	// ------------------------------------------------------------------
	// helper: stall length, kind of operation, abort seen
	// ------------------------------------------------------------------
	int   len_q;  // stalled cycles so far
	logic prog_q; // current stall is a word program
	logic hit_q;  // an abort source fired during this stall
	// the kind is latched in the launch cycle, when len_q is still zero
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			len_q <= 0;
			prog_q <= 1'b0;
			hit_q <= 1'b0;
		end else if (!o_cpu_stall) begin
			len_q <= 0;
		end else begin
			len_q <= len_q + 1;
			if (len_q == 0) begin
				prog_q <= (i_cpu_wr.sel == SEL_DATA_HIGH);
				hit_q <= 1'b0;
			end
			// later assignment wins, so a launch-cycle abort counts
			if ((i_ext_irq & o_abort_source_select) != 8'h00)
				hit_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// sequences and properties
	// ------------------------------------------------------------------
	// a write taken while the sequencer was idle
	sequence s_wr(logic [3:0] s);
		i_cpu_wr.strobe && i_cpu_wr.sel == s && !$past(o_cpu_stall);
	endsequence
	sequence s_start;
		$rose(o_cpu_stall);
	endsequence
	// an enabled abort source inside a running erase
	sequence s_kill;
		o_cpu_stall && len_q != 0 && len_q < ERASE_CYCLES && !prog_q &&
		(i_ext_irq & o_abort_source_select) != 8'h00;
	endsequence
	// no selected abort source is active
	sequence s_calm;
		(i_ext_irq & o_abort_source_select) == 8'h00;
	endsequence
	// an operation left alone keeps the stall for seven cycles
	property p_hold;
		s_start ##0 s_calm [*7] |-> o_cpu_stall;
	endproperty
	property p_erase_ok;
		$fell(o_cpu_stall) && !prog_q && !hit_q |=> !o_erase_aborted_flag;
	endproperty
	property p_erase_len;
		$fell(o_cpu_stall) && !prog_q && !hit_q |->
		len_q == ERASE_CYCLES + 1;
	endproperty
	property p_prog_len;
		$fell(o_cpu_stall) && prog_q |-> len_q == PROGRAM_CYCLES + 1;
	endproperty
	property p_abort;
		s_kill |=> !o_cpu_stall ##[0:1] o_erase_aborted_flag;
	endproperty
	property p_block_locked;
		s_wr(SEL_ERASE_CMD) ##0
		(i_cpu_wr.data[1:0] == 2'b10 && o_area_lock != 4'h0) |=> o_refused;
	endproperty
	property p_lock;
		s_wr(SEL_AREA_LOCK) |=>
		o_area_lock == ($past(o_area_lock) | $past(i_cpu_wr.data[3:0]));
	endproperty
	property p_enable;
		s_wr(SEL_ENABLE) |=> o_rewrite_enable_bit == $past(i_cpu_wr.data[0]);
	endproperty
	property p_segment;
		s_wr(SEL_SEGMENT) |=> o_segment_select == $past(i_cpu_wr.data[1:0]);
	endproperty
	property p_cancel;
		s_wr(SEL_UNLOCK) ##0 (i_cpu_wr.data != KEY_FIRST &&
		i_cpu_wr.data != KEY_SECOND) |=> !o_unlock_armed;
	endproperty
	property p_consume;
		s_wr(SEL_ERASE_CMD) ##0 (i_cpu_wr.data[1:0] != 2'b00) |=>
		!o_unlock_armed;
	endproperty

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	a_hold: assert property (p_hold)
		else $error("stall dropped early");
	a_erase_ok: assert property (p_erase_ok)
		else $error("clean erase left abort status");
	a_erase_len: assert property (p_erase_len)
		else $error("erase stall length wrong");
	a_prog_len: assert property (p_prog_len)
		else $error("program stall length wrong");
	a_abort: assert property (p_abort)
		else $error("abort not taken");
	a_block_locked: assert property (p_block_locked)
		else $error("locked block erase not refused");
	a_lock: assert property (p_lock)
		else $error("lock bits wrong");
	a_enable: assert property (p_enable)
		else $error("enable bit wrong");
	a_segment: assert property (p_segment)
		else $error("segment select wrong");
	a_cancel: assert property (p_cancel)
		else $error("wrong key left unlock armed");
	a_consume: assert property (p_consume)
		else $error("start left unlock armed");
endmodule

bind flash_rewrite_seq flash_seq_checker #(
	.ERASE_CYCLES(ERASE_CYCLES)
) u_checker (
	.i_clock(i_clock), .i_rst_n(i_rst_n), .i_cpu_wr(i_cpu_wr),
	.i_ext_irq(i_ext_irq), .o_cpu_stall(o_cpu_stall),
	.o_rewrite_enable_bit(o_rewrite_enable_bit),
	.o_segment_select(o_segment_select), .o_area_lock(o_area_lock),
	.o_abort_source_select(o_abort_source_select),
	.o_erase_aborted_flag(o_erase_aborted_flag),
	.o_refused(o_refused), .o_unlock_armed(o_unlock_armed)
);

// ---- verif/cpu_model.sv ----
// cpu model issuing special register byte writes to the sequencer
// assumes the stall output follows the sequencer's hand-over timing
`timescale 1ns/10ps
module cpu_model
	import flash_seq_pkg::*;
(
	// clock and handshake
	input  wire logic     i_clock,
	input  wire logic     i_stall,
	// write port and hang flag
	output cpu_write_type o_wr,
	output logic          o_hung
);
	// idle bus from time zero
	initial begin
		o_wr = '0;
		o_hung = 1'b0;
	end
	// wait at falling edges until the stall is gone; bounded
	task automatic settle();
		int n;
		n = 0;
		@(negedge i_clock);
		while (i_stall !== 1'b0 && n < 3000) begin
			@(negedge i_clock);
			n++;
		end
		if (n >= 3000)
			o_hung = 1'b1;
	endtask
	// one byte write, held for exactly one sampling edge
	task automatic wr(input logic [3:0] s, input logic [7:0] d);
		settle();
		@(posedge i_clock);
		o_wr <= {1'b1, s, d};
		@(posedge i_clock);
		o_wr.strobe <= 1'b0;
		// a start is followed by two idle instruction slots
		if (s == SEL_ERASE_CMD || s == SEL_DATA_HIGH)
			repeat (2) @(posedge i_clock);
	endtask
endmodule

// ---- verif/tb_top.sv ----
// self-checking bench for the rewrite sequencer driven by a cpu model
// assumes the package, checker and cpu model are compiled first
`timescale 1ns/10ps
`define CHK(a, e) begin \
	n_checks++; \
	if ((a) !== (e)) begin \
		bad_count++; \
		$display("wrong value at %0t: %h vs %h", $time, (a), (e)); \
	end \
end
module tb_top
	import flash_seq_pkg::*;
;
	localparam int ERASE = 20; // short erase keeps the run brief
	logic          i_clock;
	logic          i_rst_n;
	cpu_write_type cpu_wr;
	logic [7:0]    i_ext_irq;
	logic [10:0]   i_read_word;
	logic [15:0]   o_read_data;
	logic          stall;
	logic          en;
	logic [1:0]    seg;
	logic [3:0]    lock;
	logic [7:0]    src;
	logic          aborted;
	logic          refused;
	logic          armed;
	logic          hung;      // cpu model gave up waiting
	logic          fire;      // pulse an abort source mid-erase
	int            bad_count;
	int            n_checks;
	int            scnt;      // stall cycles since the last clear

	flash_rewrite_seq #(.ERASE_CYCLES(ERASE)) uut (
		.i_clock(i_clock), .i_rst_n(i_rst_n), .i_cpu_wr(cpu_wr),
		.i_ext_irq(i_ext_irq), .i_read_word(i_read_word),
		.o_read_data(o_read_data), .o_cpu_stall(stall),
		.o_rewrite_enable_bit(en), .o_segment_select(seg),
		.o_area_lock(lock), .o_abort_source_select(src),
		.o_erase_aborted_flag(aborted), .o_refused(refused),
		.o_unlock_armed(armed)
	);
	cpu_model cpu (
		.i_clock(i_clock), .i_stall(stall), .o_wr(cpu_wr), .o_hung(hung)
	);

	always #10 i_clock = ~i_clock;
	// stall count and abort pulse share one process to avoid races
	always @(posedge i_clock) begin
		if (stall === 1'b1)
			scnt++;
		i_ext_irq <= (fire && scnt == 5) ? 8'h01 : 8'h00;
	end
	// a hung wait ends the run as a failure
	always @(posedge hung) begin
		bad_count++;
		test_done();
	end

	task automatic test_done();
		if (bad_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic rd(input logic [10:0] w, input logic [15:0] e);
		@(posedge i_clock);
		i_read_word <= w;
		@(posedge i_clock);
		@(negedge i_clock);
		`CHK(o_read_data, e)
	endtask
	// full host sequence, then the start write and its completion
	task automatic go(input logic [7:0] ah, al, dl,
		input logic [3:0] s, input logic [7:0] d);
		cpu.wr(SEL_ENABLE, 8'h01);
		cpu.wr(SEL_UNLOCK, KEY_FIRST);
		cpu.wr(SEL_UNLOCK, KEY_SECOND);
		cpu.wr(SEL_SEGMENT, 8'h02);
		cpu.wr(SEL_ADDR_HIGH, ah);
		cpu.wr(SEL_ADDR_LOW, al);
		cpu.wr(SEL_DATA_LOW, dl);
		scnt = 0;
		cpu.wr(s, d);
		cpu.settle();
	endtask
	// sector erase of quarter 0 that must be refused
	task automatic try(input logic [7:0] ev, input logic [3:0] ks,
		input logic [7:0] kd, input logic [7:0] sg, input logic ex);
		cpu.wr(SEL_ENABLE, ev);
		cpu.wr(SEL_UNLOCK, KEY_FIRST);
		cpu.wr(ks, kd);
		cpu.wr(SEL_UNLOCK, KEY_SECOND);
		cpu.wr(SEL_SEGMENT, sg);
		`CHK(armed, ex)
		cpu.wr(SEL_ADDR_HIGH, 8'h00);
		scnt = 0;
		cpu.wr(SEL_ERASE_CMD, 8'h01);
		cpu.settle();
		`CHK({refused, armed, scnt}, {2'b10, 32'd0})
		rd(11'h001, 16'habcd);
	endtask

	task automatic t_reset();
		@(negedge i_clock);
		`CHK({en, seg, lock, src, aborted, refused, armed}, 18'h0)
	endtask
	task automatic t_block();
		go(8'h00, 8'h00, 8'h00, SEL_ERASE_CMD, 8'h02);
		`CHK(scnt, ERASE + 1)
		`CHK(scnt < 6_250_000, 1'b1)
		`CHK(armed, 1'b0)
		rd(11'h000, ERASED_WORD);
		rd(11'h7ff, ERASED_WORD);
	endtask
	task automatic t_program();
		go(8'h04, 8'h02, 8'h34, SEL_DATA_HIGH, 8'h12);
		`CHK(scnt, PROGRAM_CYCLES + 1)
		rd(11'h201, 16'h1234);
		rd(11'h200, ERASED_WORD);
		go(8'h00, 8'h02, 8'hcd, SEL_DATA_HIGH, 8'hab);
		rd(11'h001, 16'habcd);
	endtask
	task automatic t_sector();
		go(8'h04, 8'h00, 8'h00, SEL_ERASE_CMD, 8'h01);
		`CHK(scnt, ERASE + 1)
		rd(11'h201, ERASED_WORD);
		rd(11'h001, 16'habcd);
	endtask
	task automatic t_refuse();
		try(8'h00, SEL_ADDR_LOW, 8'h00, 8'h02, 1'b1);
		try(8'h01, SEL_UNLOCK, 8'h00, 8'h02, 1'b0);
		try(8'h01, SEL_ADDR_LOW, 8'h00, 8'h00, 1'b1);
		try(8'h01, SEL_ADDR_LOW, 8'h00, 8'h01, 1'b1);
		try(8'h01, SEL_ADDR_LOW, 8'h00, 8'h03, 1'b1);
	endtask
	task automatic t_lock();
		go(8'h04, 8'h02, 8'h55, SEL_DATA_HIGH, 8'h55);
		cpu.wr(SEL_AREA_LOCK, 8'h02);
		cpu.wr(SEL_AREA_LOCK, 8'h00);
		@(negedge i_clock);
		`CHK(lock, 4'h2)
		go(8'h07, 8'h00, 8'h00, SEL_ERASE_CMD, 8'h01);
		`CHK({refused, scnt}, {1'b1, 32'd0})
		rd(11'h201, 16'h5555);
		go(8'h00, 8'h00, 8'h00, SEL_ERASE_CMD, 8'h02);
		`CHK({refused, scnt}, {1'b1, 32'd0})
		rd(11'h001, 16'habcd);
		go(8'h03, 8'h00, 8'h00, SEL_ERASE_CMD, 8'h01);
		rd(11'h001, ERASED_WORD);
	endtask
	task automatic t_abort();
		cpu.wr(SEL_ABORT_SRC, 8'h01);
		fire = 1'b1;
		go(8'h08, 8'h00, 8'h00, SEL_ERASE_CMD, 8'h01);
		fire = 1'b0;
		repeat (2) @(negedge i_clock);
		`CHK({src, aborted, scnt < ERASE}, 10'h007)
		// a clean re-run of the cut erase clears the status
		go(8'h08, 8'h00, 8'h00, SEL_ERASE_CMD, 8'h01);
		@(negedge i_clock);
		`CHK({aborted, scnt}, {1'b0, ERASE + 1})
		fire = 1'b1;
		go(8'h08, 8'h00, 8'h00, SEL_ERASE_CMD, 8'h01);
		fire = 1'b0;
		cpu.wr(SEL_ERASE_STAT, 8'h00);
		@(negedge i_clock);
		`CHK(aborted, 1'b0)
	endtask

	initial begin
		i_clock = 1'b0;
		i_rst_n = 1'b0;
		i_read_word = 11'h000;
		fire = 1'b0;
		bad_count = 0;
		n_checks = 0;
		scnt = 0;
		repeat (20) @(posedge i_clock);
		i_rst_n <= 1'b1;
		t_reset();
		t_block();
		t_program();
		t_sector();
		t_refuse();
		t_lock();
		t_abort();
		test_done();
	end
endmodule
